// *** hw/drive_monitor_defs.vh ***
`ifndef DRIVE_MONITOR_DEFS_VH
`define DRIVE_MONITOR_DEFS_VH

// register numbers on the serial link
`define REG_INPUT_TERMINAL_STATES 16'h002B
`define REG_DRIVE_CONDITION_WORD 16'h002C
`define REG_OUTPUT_TERMINAL_STATES 16'h002D
`define REG_SCALED_FREQ_MONITOR_A 16'h0038
`define REG_SCALED_FREQ_MONITOR_B 16'h0039
`define REG_SIGNED_FREQ_MONITOR 16'h003A
`define REG_MAIN_CPU_SW_NUMBER 16'h003B
`define REG_STORED_PROG_SW_NUMBER 16'h003C
`define REG_LINK_ERROR_DETAILS 16'h003D
`define REG_CAPACITY_SETTING 16'h003E
`define REG_CONTROL_METHOD_SETTING 16'h003F

// drive condition word bit positions
`define DCW_RUNNING 0
`define DCW_ZERO_SPEED 1
`define DCW_FREQ_AGREE 2
`define DCW_DESIRED_AGREE 3
`define DCW_FREQ_DETECT_1 4
`define DCW_FREQ_DETECT_2 5
`define DCW_STARTUP_DONE 6
`define DCW_LOW_VOLTAGE 7
`define DCW_OUTPUT_BLOCKED 8
`define DCW_REF_NOT_LINK 9
`define DCW_RUN_NOT_LINK 10
`define DCW_OVERTORQUE 11
`define DCW_REF_LOST 12
`define DCW_RETRYING 13
`define DCW_FAULT 14
`define DCW_LINK_TIMEOUT 15

// link error detail bit positions
`define LED_CRC 0
`define LED_LENGTH 1
`define LED_PARITY 3
`define LED_OVERRUN 4
`define LED_FRAMING 5
`define LED_TIMEOUT 6

// used-bit masks, unused bits read zero
`define MASK_INPUT_TERMINALS 16'h007F
`define MASK_OUTPUT_TERMINALS 16'h0003
`define MASK_LINK_ERRORS 16'h007B

// reset value of every held register
`define RESET_WORD 16'h0000

// 10 counts per 1 percent, so full scale is 1000 counts
`define SCALE_FULL 26'h000_03E8
`define DIV_STEPS 5'h1A
`define SIGNED_MAX 16'h7FFF
`define UNSIGNED_MAX 16'hFFFF

// answer codes for refused accesses
`define CODE_NONE 8'h00
`define CODE_BAD_REGISTER 8'h02
`define CODE_WRITE_REFUSED 8'h22

`endif

// *** hw/drive_monitor_status_registers.v ***
// Summary of operation
// RL1 - input terminal states 1..7 appear in bits 0..6, 1 means on
// RL2 - frequency detect 1 set while output frequency at or below threshold
// RL3 - frequency detect 2 set while output frequency at or above threshold
// RL4 - output shut-off flag reads 1 whenever power output is blocked
// RL5 - two bits say reference and run source: 0 link, 1 other
// RL6 - a status flag reads 1 after a link time-out error
// RL7 - digital outputs 1 and 2 appear in bits 0 and 1, 1 means on
// RL8 - link error flags latch until an error reset arrives
// RL9 - error reset clears latched errors even while running
// RL10 - two unsigned monitors scaled so 10 counts equal 1 percent
// RL11 - signed monitor scaled the same way, both polarities
// RL12 - monitor registers are read only; writes change nothing
// RL13 - unused bits in status, output and error registers read 0
`include "drive_monitor_defs.vh"
`timescale 1ns/10ps
`default_nettype none

module drive_monitor_status_registers #(
	parameter FW = 16
) (
	// clock and reset
	input wire clk_i,
	input wire rstn_i,
	// terminal pins, asynchronous
	input wire [6:0] input_terminal_i,
	// drive logic, same clock
	input wire [1:0] digital_output_i,
	input wire running_i,
	input wire zero_speed_i,
	input wire freq_agree_i,
	input wire desired_agree_i,
	input wire startup_done_i,
	input wire low_voltage_i,
	input wire output_blocked_i,
	input wire ref_not_link_i,
	input wire run_not_link_i,
	input wire overtorque_i,
	input wire ref_lost_i,
	input wire retrying_i,
	input wire fault_i,
	input wire reverse_i,
	// frequency values, raw drive units
	input wire [FW-1:0] freq_reference_i,
	input wire [FW-1:0] output_freq_i,
	input wire [FW-1:0] max_output_freq_i,
	input wire [FW-1:0] frequency_detect_threshold_i,
	// fixed identity and setting words
	input wire [15:0] cpu_sw_number_i,
	input wire [15:0] stored_sw_number_i,
	input wire [15:0] capacity_i,
	input wire [15:0] control_method_i,
	// link error events, one-cycle pulses
	input wire crc_err_i,
	input wire length_err_i,
	input wire parity_err_i,
	input wire overrun_err_i,
	input wire framing_err_i,
	input wire timeout_err_i,
	input wire err_reset_i,
	// register access from the link framer
	input wire rd_req_i,
	input wire wr_req_i,
	input wire [15:0] addr_i,
	output reg ack_o,
	output reg [15:0] rd_data_o,
	output reg [7:0] err_code_o,
	// timeout flag for the link framer
	output reg link_timeout_o
);

// divider sequencer states; idle is only seen after reset
localparam ST_IDLE = 2'h0;
localparam ST_LOAD = 2'h1;
localparam ST_RUN = 2'h2;
localparam ST_STORE = 2'h3;

// true for every register number this bank answers
function reg_mapped;
	input [15:0] a;
	begin
		case (a)
		`REG_INPUT_TERMINAL_STATES,
		`REG_DRIVE_CONDITION_WORD,
		`REG_OUTPUT_TERMINAL_STATES,
		`REG_SCALED_FREQ_MONITOR_A,
		`REG_SCALED_FREQ_MONITOR_B,
		`REG_SIGNED_FREQ_MONITOR,
		`REG_MAIN_CPU_SW_NUMBER,
		`REG_STORED_PROG_SW_NUMBER,
		`REG_LINK_ERROR_DETAILS,
		`REG_CAPACITY_SETTING,
		`REG_CONTROL_METHOD_SETTING: reg_mapped = 1'b1;
		default: reg_mapped = 1'b0;
		endcase
	end
endfunction

// clamp a wide quotient to a 16-bit ceiling
function [15:0] clamp16;
	input [25:0] q;
	input [15:0] ceil;
	begin
		if (q > {10'h000, ceil}) begin
			clamp16 = ceil;
		end else begin
			clamp16 = q[15:0];
		end
	end
endfunction

// synchronised pins and latched link errors
wire [6:0] terminals_sync;
wire [15:0] err_flags;
wire [15:0] err_events;

// held status words and scaled monitors
reg [15:0] input_states_r;
reg [15:0] condition_r;
reg [15:0] output_states_r;
reg [15:0] monitor_a_r;
reg [15:0] monitor_b_r;
reg [15:0] monitor_s_r;

// divider sequencer and working registers
reg [1:0] state_r;
reg [1:0] state_nxt;
reg chan_r;
reg neg_r;
reg [15:0] divisor_r;
reg [25:0] num_r;
reg [16:0] rem_r;
reg [4:0] step_r;

// combinational next values
reg [15:0] cond_nxt;
reg [15:0] rd_nxt;
reg [7:0] code_nxt;

// terminals come from pins, so resynchronise them first
pin_sync #(
	.W(7)
) u_term_sync (
	.clk_i(clk_i),
	.rstn_i(rstn_i),
	.pin_i(input_terminal_i),
	.sync_o(terminals_sync)
);

// error event vector, unused positions tied low
assign err_events = {9'h000,
	timeout_err_i,
	framing_err_i,
	overrun_err_i,
	parity_err_i,
	1'b0,
	length_err_i,
	crc_err_i}; // RL8 RL13

error_latch #(
	.W(16)
) u_err_latch (
	.clk_i(clk_i),
	.rstn_i(rstn_i),
	.set_i(err_events),
	.clr_i(err_reset_i), // RL9
	.flags_o(err_flags)
);

// drive condition word from live drive signals
always @* begin
	cond_nxt = `RESET_WORD;
	cond_nxt[`DCW_RUNNING] = running_i;
	cond_nxt[`DCW_ZERO_SPEED] = zero_speed_i;
	cond_nxt[`DCW_FREQ_AGREE] = freq_agree_i;
	cond_nxt[`DCW_DESIRED_AGREE] = desired_agree_i;
	// both compares are inclusive, so at the threshold both flags read 1
	cond_nxt[`DCW_FREQ_DETECT_1] = (output_freq_i <= frequency_detect_threshold_i); // RL2
	cond_nxt[`DCW_FREQ_DETECT_2] = (output_freq_i >= frequency_detect_threshold_i); // RL3
	cond_nxt[`DCW_STARTUP_DONE] = startup_done_i;
	cond_nxt[`DCW_LOW_VOLTAGE] = low_voltage_i;
	cond_nxt[`DCW_OUTPUT_BLOCKED] = output_blocked_i; // RL4
	cond_nxt[`DCW_REF_NOT_LINK] = ref_not_link_i; // RL5
	cond_nxt[`DCW_RUN_NOT_LINK] = run_not_link_i; // RL5
	cond_nxt[`DCW_OVERTORQUE] = overtorque_i;
	cond_nxt[`DCW_REF_LOST] = ref_lost_i;
	cond_nxt[`DCW_RETRYING] = retrying_i;
	cond_nxt[`DCW_FAULT] = fault_i;
	// held time-out shows until the error reset clears it
	cond_nxt[`DCW_LINK_TIMEOUT] = err_flags[`LED_TIMEOUT]; // RL6
end

// snapshot of status words, refreshed every cycle
always @(posedge clk_i or negedge rstn_i) begin
	if (!rstn_i) begin
		input_states_r <= `RESET_WORD;
		condition_r <= `RESET_WORD;
		output_states_r <= `RESET_WORD;
		link_timeout_o <= 1'b0;
	end else begin
		input_states_r <= {9'h000, terminals_sync}; // RL1 RL13
		condition_r <= cond_nxt;
		output_states_r <= {14'h0000, digital_output_i}; // RL7 RL13
		// the framer sees the same latched time-out as the status word
		link_timeout_o <= err_flags[`LED_TIMEOUT];
	end
end

// scaling sequencer: one shared divider serves both channels,
// trading a refresh latency of about 60 cycles for area
always @* begin
	case (state_r)
	ST_IDLE: state_nxt = ST_LOAD;
	ST_LOAD: state_nxt = ST_RUN;
	ST_RUN: begin
		if (step_r == 5'h00) begin
			state_nxt = ST_STORE;
		end else begin
			state_nxt = ST_RUN;
		end
	end
	ST_STORE: state_nxt = ST_LOAD;
	default: state_nxt = ST_IDLE;
	endcase
end

// restoring divider, quotient = freq * 1000 / max freq
wire [16:0] rem_shift = {rem_r[15:0], num_r[25]};
wire [16:0] rem_trial = rem_shift - {1'b0, divisor_r};
wire [FW-1:0] chan_freq = chan_r ? output_freq_i : freq_reference_i;
wire [25:0] scaled_num = {10'h000, chan_freq} * `SCALE_FULL;
// signed result keeps one bit for the sign, hence the lower ceiling
wire [15:0] signed_mag = clamp16(num_r, `SIGNED_MAX);

always @(posedge clk_i or negedge rstn_i) begin
	if (!rstn_i) begin
		state_r <= ST_IDLE;
		chan_r <= 1'b0;
		neg_r <= 1'b0;
		divisor_r <= `RESET_WORD;
		num_r <= 26'h000_0000;
		rem_r <= 17'h0_0000;
		step_r <= 5'h00;
		monitor_a_r <= `RESET_WORD;
		monitor_b_r <= `RESET_WORD;
		monitor_s_r <= `RESET_WORD;
	end else begin
		state_r <= state_nxt;
		case (state_r)
		ST_LOAD: begin
			// sample the sign with its operands so one pass is self-consistent
			num_r <= scaled_num;
			divisor_r <= max_output_freq_i;
			neg_r <= reverse_i;
			rem_r <= 17'h0_0000;
			step_r <= `DIV_STEPS;
		end
		ST_RUN: begin
			// one quotient bit per cycle, most significant first
			if (step_r != 5'h00) begin
				step_r <= step_r - 5'h01;
				if (!rem_trial[16]) begin
					rem_r <= rem_trial;
					num_r <= {num_r[24:0], 1'b1};
				end else begin
					rem_r <= rem_shift;
					num_r <= {num_r[24:0], 1'b0};
				end
			end
		end
		ST_STORE: begin
			// a zero maximum would divide by zero, so report zero
			if (divisor_r == `RESET_WORD) begin
				if (chan_r) begin
					monitor_b_r <= `RESET_WORD;
					monitor_s_r <= `RESET_WORD;
				end else begin
					monitor_a_r <= `RESET_WORD;
				end
			end else if (chan_r) begin
				monitor_b_r <= clamp16(num_r, `UNSIGNED_MAX); // RL10
				if (neg_r) begin
					monitor_s_r <= `RESET_WORD - signed_mag; // RL11
				end else begin
					monitor_s_r <= signed_mag; // RL11
				end
			end else begin
				monitor_a_r <= clamp16(num_r, `UNSIGNED_MAX); // RL10
			end
			// alternate channels, so each refreshes every second pass
			chan_r <= ~chan_r;
		end
		default: begin
			chan_r <= 1'b0;
		end
		endcase
	end
end

// read decode; writes are answered with a refusal and touch nothing
always @* begin
	rd_nxt = `RESET_WORD;
	code_nxt = `CODE_NONE;
	if (wr_req_i) begin
		code_nxt = `CODE_WRITE_REFUSED; // RL12
		// no write data reaches this block, so a write cannot alter a word
	end else if (rd_req_i) begin
		if (!reg_mapped(addr_i)) begin
			code_nxt = `CODE_BAD_REGISTER;
		end
		case (addr_i)
		`REG_INPUT_TERMINAL_STATES: rd_nxt = input_states_r & `MASK_INPUT_TERMINALS; // RL13
		`REG_DRIVE_CONDITION_WORD: rd_nxt = condition_r;
		`REG_OUTPUT_TERMINAL_STATES: rd_nxt = output_states_r & `MASK_OUTPUT_TERMINALS;
		`REG_SCALED_FREQ_MONITOR_A: rd_nxt = monitor_a_r;
		`REG_SCALED_FREQ_MONITOR_B: rd_nxt = monitor_b_r;
		`REG_SIGNED_FREQ_MONITOR: rd_nxt = monitor_s_r;
		`REG_MAIN_CPU_SW_NUMBER: rd_nxt = cpu_sw_number_i;
		`REG_STORED_PROG_SW_NUMBER: rd_nxt = stored_sw_number_i;
		`REG_LINK_ERROR_DETAILS: rd_nxt = err_flags & `MASK_LINK_ERRORS; // RL8 RL13
		`REG_CAPACITY_SETTING: rd_nxt = capacity_i;
		`REG_CONTROL_METHOD_SETTING: rd_nxt = control_method_i;
		default: rd_nxt = `RESET_WORD;
		endcase
	end
end

// answer registers, one cycle after the request
always @(posedge clk_i or negedge rstn_i) begin
	if (!rstn_i) begin
		ack_o <= 1'b0;
		rd_data_o <= `RESET_WORD;
		err_code_o <= `CODE_NONE;
	end else begin
		// every request is answered, refused or not, so the framer never waits
		ack_o <= rd_req_i | wr_req_i;
		rd_data_o <= rd_nxt;
		err_code_o <= code_nxt;
	end
end

endmodule // drive_monitor_status_registers

`default_nettype wire

// *** hw/error_latch.v ***
`timescale 1ns/10ps
`default_nettype none

module error_latch #(
	parameter W = 16
) (
	// clock and reset
	input wire clk_i,
	input wire rstn_i,
	// error events and reset request
	input wire [W-1:0] set_i,
	input wire clr_i,
	// held flags
	output reg [W-1:0] flags_o
);

reg [W-1:0] flags_nxt;

// set beats clear so an error in the reset cycle is kept
always @* begin
	flags_nxt = (flags_o & ~{W{clr_i}}) | set_i; // RL8 RL9
end

always @(posedge clk_i or negedge rstn_i) begin
	if (!rstn_i) begin
		flags_o <= {W{1'b0}};
	end else begin
		flags_o <= flags_nxt;
	end
end

endmodule // error_latch

`default_nettype wire

// *** hw/pin_sync.v ***
`timescale 1ns/10ps
`default_nettype none

module pin_sync #(
	parameter W = 7
) (
	// clock and reset
	input wire clk_i,
	input wire rstn_i,
	// pin side and synchronised side
	input wire [W-1:0] pin_i,
	output reg [W-1:0] sync_o
);

reg [W-1:0] meta_r;

// two stages; only the second stage is read downstream
always @(posedge clk_i or negedge rstn_i) begin
	if (!rstn_i) begin
		meta_r <= {W{1'b0}};
		sync_o <= {W{1'b0}};
	end else begin
		meta_r <= pin_i;
		sync_o <= meta_r;
	end
end

endmodule // pin_sync

`default_nettype wire

// *** sim/drive_monitor_chk.sv ***
`timescale 1ns/10ps
`default_nettype none

module drive_monitor_chk (
	// clock and reset
	input wire clk_i,
	input wire rstn_i,
	// register access
	input wire rd_req_i,
	input wire wr_req_i,
	input wire [15:0] addr_i,
	input wire ack_o,
	input wire [15:0] rd_data_o,
	input wire [7:0] err_code_o,
	// error latch
	input wire timeout_err_i,
	input wire err_reset_i,
	input wire link_timeout_o
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!rstn_i);
	// plain read of one register
	sequence s_rd(a);
		rd_req_i && !wr_req_i && addr_i == a;
	endsequence
	// flag already seen with no reset before it
	sequence s_held;
		!err_reset_i ##1 link_timeout_o;
	endsequence
	property p_ack;
		rd_req_i || wr_req_i |=> ack_o;
	endproperty
	a_ack: assert property (p_ack) else $error("request not answered");
	property p_idle;
		!(rd_req_i || wr_req_i) |=> !ack_o && rd_data_o == 16'h0000;
	endproperty
	a_idle: assert property (p_idle) else $error("answer without request");
	property p_wr;
		wr_req_i |=> err_code_o == 8'h22 && rd_data_o == 16'h0000;
	endproperty
	a_wr: assert property (p_wr) else $error("write not refused");
	property p_term;
		s_rd(16'h002B) |=> rd_data_o[15:7] == 9'h000 && err_code_o == 8'h00;
	endproperty
	a_term: assert property (p_term) else $error("terminal spare bits");
	property p_outs;
		s_rd(16'h002D) |=> rd_data_o[15:2] == 14'h0000;
	endproperty
	a_outs: assert property (p_outs) else $error("output spare bits");
	property p_errd;
		s_rd(16'h003D) |=> (rd_data_o & 16'hFF84) == 16'h0000;
	endproperty
	a_errd: assert property (p_errd) else $error("error spare bits");
	property p_tset;
		timeout_err_i |-> ##2 link_timeout_o;
	endproperty
	a_tset: assert property (p_tset) else $error("timeout not flagged");
	property p_thold;
		s_held |=> link_timeout_o;
	endproperty
	a_thold: assert property (p_thold) else $error("timeout flag lost");
	property p_tclr;
		err_reset_i && !timeout_err_i |-> ##2 !link_timeout_o;
	endproperty
	a_tclr: assert property (p_tclr) else $error("timeout not cleared");
endmodule // drive_monitor_chk

bind drive_monitor_status_registers drive_monitor_chk u_chk (
	.clk_i, .rstn_i, .rd_req_i, .wr_req_i, .addr_i, .ack_o, .rd_data_o,
	.err_code_o, .timeout_err_i, .err_reset_i, .link_timeout_o
);

`default_nettype wire

// *** sim/link_master.sv ***
`timescale 1ns/10ps
`default_nettype none

module link_master (
	// clock
	input wire logic clk_i,
	// request side
	output logic rd_o,
	output logic wr_o,
	output logic [15:0] adr_o,
	// answer side
	input wire logic ack_i,
	input wire logic [15:0] dat_i,
	input wire logic [7:0] code_i
);
	// idle until the bench asks
	initial begin
		rd_o = 1'b0;
		wr_o = 1'b0;
		adr_o = 16'h0000;
	end
	// one-cycle request pulse, answer taken one cycle on
	task automatic xfer(input logic w, input logic [15:0] a,
		output logic [15:0] d, output logic [7:0] c, output logic k);
		@(negedge clk_i);
		rd_o = !w;
		wr_o = w;
		adr_o = a;
		@(negedge clk_i);
		rd_o = 1'b0;
		wr_o = 1'b0;
		adr_o = ~a; // no stale address between requests
		d = dat_i;
		c = code_i;
		k = ack_i;
	endtask
endmodule // link_master

`default_nettype wire

// *** sim/tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none

module tb_top;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [6:0] tin = 7'h00;
	logic [1:0] dout = 2'h0;
	logic [15:0] st = 16'h0000;
	logic rev = 1'b0;
	logic [15:0] fref = 16'h0000, fout = 16'h0000, fmax = 16'h0000, thr = 16'h0000;
	logic [15:0] sw [4] = '{16'h1234, 16'hA5C3, 16'h0F0F, 16'h0003};
	logic [15:0] ra [4] = '{16'h003B, 16'h003C, 16'h003E, 16'h003F};
	logic [6:0] tv [4] = '{7'h55, 7'h2A, 7'h7F, 7'h00};
	logic [15:0] sv [3] = '{16'h5545, 16'h2A8A, 16'h7FCF};
	int bp [6] = '{0, 1, 3, 4, 5, 6};
	logic [5:0] e = 6'h00;
	logic erst = 1'b0;
	logic rq, wq, ack, lto;
	logic [15:0] adr, dat, ex;
	logic [7:0] code;
	int n_fail = 0, num_checks = 0, cyc = 0;

	// free-running clock, 10 ns
	always #5 clk = ~clk;
	// hang guard, tests take well under a thousand cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			wrap_up();
		end
	end

	drive_monitor_status_registers #(.FW(16)) u_dut (
		.clk_i(clk), .rstn_i(rstn), .input_terminal_i(tin),
		.digital_output_i(dout), .running_i(st[0]), .zero_speed_i(st[1]),
		.freq_agree_i(st[2]), .desired_agree_i(st[3]), .startup_done_i(st[6]),
		.low_voltage_i(st[7]), .output_blocked_i(st[8]), .ref_not_link_i(st[9]),
		.run_not_link_i(st[10]), .overtorque_i(st[11]), .ref_lost_i(st[12]),
		.retrying_i(st[13]), .fault_i(st[14]), .reverse_i(rev),
		.freq_reference_i(fref), .output_freq_i(fout), .max_output_freq_i(fmax),
		.frequency_detect_threshold_i(thr), .cpu_sw_number_i(sw[0]),
		.stored_sw_number_i(sw[1]), .capacity_i(sw[2]), .control_method_i(sw[3]),
		.crc_err_i(e[0]), .length_err_i(e[1]), .parity_err_i(e[2]),
		.overrun_err_i(e[3]), .framing_err_i(e[4]), .timeout_err_i(e[5]),
		.err_reset_i(erst), .rd_req_i(rq), .wr_req_i(wq), .addr_i(adr),
		.ack_o(ack), .rd_data_o(dat), .err_code_o(code), .link_timeout_o(lto)
	);

	link_master u_mst (
		.clk_i(clk), .rd_o(rq), .wr_o(wq), .adr_o(adr),
		.ack_i(ack), .dat_i(dat), .code_i(code)
	);

	// compare and count
	task automatic chk(input logic [15:0] g, input logic [15:0] x);
		num_checks++;
		if (g !== x) begin
			n_fail++;
			$display("[ERR] t=%0t got %h exp %h", $time, g, x);
		end
	endtask
	// one access, then ack, data and answer code
	task automatic acc(input logic w, input logic [15:0] a,
		input logic [15:0] x, input logic [7:0] xc);
		logic [15:0] d;
		logic [7:0] c;
		logic k;
		u_mst.xfer(w, a, d, c, k);
		chk({15'h0000, k}, 16'h0001);
		chk(d, x);
		chk({8'h00, c}, {8'h00, xc});
	endtask
	task automatic rd(input logic [15:0] a, input logic [15:0] x);
		acc(1'b0, a, x, 8'h00);
	endtask
	task automatic nc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// main sequence, inputs move at falling edges only
	initial begin
		nc(3);
		rstn = 1'b1;
		foreach (tv[i]) begin
			tin = tv[i];
			dout = i[1:0];
			nc(4);
			rd(16'h002B, {9'h000, tin});
			rd(16'h002D, {14'h0000, dout});
		end
		// threshold one below, equal, one above output frequency
		fout = 16'h0064;
		for (int i = 0; i < 3; i++) begin
			st = sv[i];
			thr = 16'h0063 + i[15:0];
			nc(3);
			rd(16'h002C, st | {10'h000, i <= 1, i >= 1, 4'h0});
		end
		foreach (ra[i])
			rd(ra[i], sw[i]);
		// reference at full scale, output at 30 percent
		fmax = 16'h07D0;
		fref = 16'h07D0;
		fout = 16'h0258;
		// worst case is a stale pass plus two fresh passes of 29 cycles
		nc(100);
		rd(16'h0038, 16'h03E8);
		rd(16'h0039, 16'h012C);
		rd(16'h003A, 16'h012C);
		rev = 1'b1;
		nc(100);
		rd(16'h003A, 16'hFED4);
		// tiny maximum overflows to the ceilings, zero maximum reads zero
		fmax = 16'h0001;
		nc(100);
		rd(16'h0038, 16'hFFFF);
		rd(16'h0039, 16'hFFFF);
		rd(16'h003A, 16'h8001);
		fmax = 16'h0000;
		nc(100);
		rd(16'h0038, 16'h0000);
		rd(16'h0039, 16'h0000);
		rd(16'h003A, 16'h0000);
		// error flags accumulate while running
		st[0] = 1'b1;
		ex = 16'h0000;
		foreach (bp[i]) begin
			e = 6'h01 << i;
			nc(1);
			e = 6'h00;
			ex = ex | (16'h0001 << bp[i]);
			rd(16'h003D, ex);
		end
		chk({15'h0000, lto}, 16'h0001);
		rd(16'h002C, 16'hFFEF);
		nc(5);
		rd(16'h003D, 16'h007B);
		erst = 1'b1;
		nc(1);
		erst = 1'b0;
		rd(16'h003D, 16'h0000);
		rd(16'h002C, 16'h7FEF);
		// refused writes leave contents, unmapped reads refused
		acc(1'b1, 16'h002D, 16'h0000, 8'h22);
		rd(16'h002D, 16'h0003);
		acc(1'b1, 16'h003F, 16'h0000, 8'h22);
		rd(16'h003F, sw[3]);
		acc(1'b0, 16'h0030, 16'h0000, 8'h02);
		acc(1'b0, 16'h0040, 16'h0000, 8'h02);
		wrap_up();
	end
endmodule // tb_top

`default_nettype wire
